// ===== core/pssp_pkg.sv
// pssp_pkg: constants, register map and shared helpers of the sram port.
// assumes a single core clock shared by both ends of the sram link.
package pssp_pkg;
    // sram word and burst geometry
    localparam int DATA_W = 18;
    localparam int LANES = 2;
    localparam int LANE_W = 9;
    localparam int CNT_W = 2;
    localparam int BEATS = 4;
    localparam int DEF_ADDR_W = 8;
    localparam int MAX_ADDR_W = 18;
    // controller register map (byte addresses)
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] OFS_ADDR = 8'h08;
    localparam logic [APB_AW-1:0] OFS_CFG = 8'h0C;
    localparam logic [3:0] PAGE_WDATA = 4'h1;
    localparam logic [3:0] PAGE_RDATA = 4'h2;
    // field positions
    localparam int CTRL_GO = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_LEN = 2;
    localparam int CTRL_CSTB = 4;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int CFG_ILV = 0;
    localparam int CFG_SLEEP = 1;
    localparam int CFG_LANE = 2;
    localparam int CFG_GLOBAL = 4;
    // reset values
    localparam logic CFG_ILV_RST = 1'b1;
    localparam logic [LANES-1:0] CFG_LANE_RST = 2'h0;

    typedef enum logic [1:0] {
        PSSP_IDLE = 2'b00,
        PSSP_ISSUE = 2'b01,
        PSSP_DRAIN = 2'b10
    } pssp_host_state_e;

    // location of step k of a burst that began at b
    function automatic logic [CNT_W-1:0] pssp_burst_loc(
        input logic [CNT_W-1:0] b, input logic [CNT_W-1:0] k, input logic ilv);
        return ilv ? (b ^ k) : CNT_W'(b + k);
    endfunction
endpackage

// ===== core/pssp_if.sv
// pssp_if: sram link between the cache controller end and the sram end.
// assumes both ends run on the same core clock; data wire resolved here.
`timescale 1ns/10ps
interface pssp_if #(parameter int ADDR_W = pssp_pkg::DEF_ADDR_W);
    import pssp_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic first_chip_select_n;
    logic second_chip_select;
    logic third_chip_select_n;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_advance_n;
    logic global_write_n;
    logic byte_write_enable_n;
    logic [LANES-1:0] byte_lane_select_n;
    logic out_drive_enable_n;
    logic sleep_request;
    logic burst_order;
    logic [DATA_W-1:0] dev_dq;
    logic dev_dq_oe;
    logic [DATA_W-1:0] host_dq;
    logic host_dq_oe;
    logic [DATA_W-1:0] dq;

    // undriven bus reads as zero
    assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : '0);

    modport dev_mp (
        input addr, first_chip_select_n, second_chip_select, third_chip_select_n,
        input processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
        input global_write_n, byte_write_enable_n, byte_lane_select_n,
        input out_drive_enable_n, sleep_request, burst_order, dq,
        output dev_dq, dev_dq_oe
    );
    modport host_mp (
        output addr, first_chip_select_n, second_chip_select, third_chip_select_n,
        output processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
        output global_write_n, byte_write_enable_n, byte_lane_select_n,
        output out_drive_enable_n, sleep_request, burst_order, host_dq, host_dq_oe,
        input dq
    );
endinterface

// ===== core/pssp_dev.sv
// pssp_dev: pipelined double-cycle-deselect sram end of the link.
// assumes the controller end shares CORE_CLK; output enable and sleep
// come from that end, so no extra synchroniser on the control pins.
`timescale 1ns/10ps
module pssp_dev #(
    parameter int ADDR_W = pssp_pkg::DEF_ADDR_W
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // sram link
    pssp_if.dev_mp LINK,
    // status
    output logic SLEEP_ACTIVE
);
    import pssp_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;

    if (ADDR_W <= CNT_W || ADDR_W > MAX_ADDR_W) begin : g_bad_addr_w
        $error("pssp_dev: ADDR_W out of range");
    end
    if (LANES * LANE_W != DATA_W) begin : g_bad_lanes
        $error("pssp_dev: lanes do not fill the word");
    end

    typedef logic [DATA_W-1:0] pssp_word_t;

    typedef struct packed {
        pssp_word_t [DEPTH-1:0] mem;
        logic [ADDR_W-1:0] base;
        logic [CNT_W-1:0] start;
        logic [CNT_W-1:0] step;
        logic active;
        logic rd;
        logic drive;
        pssp_word_t dout;
        logic [1:0] slp;
        logic order;
    } pssp_dev_state_s;

    pssp_dev_state_s s_q;
    pssp_dev_state_s s_d;

    logic sel;
    logic stb_p;
    logic stb_c;
    logic wr;
    logic [LANES-1:0] lane_we;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] wr_addr;

    // lanes a write cycle touches; global write wins over the byte controls
    function automatic logic [LANES-1:0] lane_enables(
        input logic all_n, input logic byte_n, input logic [LANES-1:0] lane_sel_n);
        logic [LANES-1:0] en;
        en = '0;
        for (int i = 0; i < LANES; i++) begin
            en[i] = ~all_n | (~byte_n & ~lane_sel_n[i]);
        end
        return en;
    endfunction

    // full word address of the current burst location
    function automatic logic [ADDR_W-1:0] burst_addr(
        input logic [ADDR_W-1:0] base, input logic [CNT_W-1:0] start,
        input logic [CNT_W-1:0] step, input logic ilv);
        return {base[ADDR_W-1:CNT_W], pssp_burst_loc(start, step, ilv)};
    endfunction

    always_comb begin
        s_d = s_q;
        wr = 1'b0;
        wr_addr = '0;

        // selected only with all three selects at their active level
        sel = ~LINK.first_chip_select_n & LINK.second_chip_select
            & ~LINK.third_chip_select_n;
        stb_p = ~LINK.processor_addr_strobe_n & ~LINK.first_chip_select_n;
        stb_c = ~LINK.controller_addr_strobe_n & ~stb_p;
        lane_we = lane_enables(LINK.global_write_n, LINK.byte_write_enable_n,
            LINK.byte_lane_select_n);

        // strap is static; sampled every edge so a change simply follows
        s_d.order = LINK.burst_order;

        // sleep request through two flops; first flop feeds only the second
        s_d.slp = {s_q.slp[0], LINK.sleep_request};

        // output register: data addressed at the previous edge
        rd_addr = burst_addr(s_q.base, s_q.start, s_q.step, s_q.order);
        s_d.dout = s_q.mem[rd_addr];
        // drive follows the read pipeline by one edge: a fresh read from
        // deselect stays floating for its first clock, and a deselect lets
        // the last read drive one more clock
        s_d.drive = s_q.rd;
        s_d.rd = 1'b0;

        if (s_q.slp[1]) begin
            // pending accesses are dropped; memory kept
            s_d.active = 1'b0;
            s_d.drive = 1'b0;
        end else if (stb_p | stb_c) begin
            if (sel) begin
                // new access: capture address, counter starts at low bits
                s_d.base = LINK.addr;
                s_d.start = LINK.addr[CNT_W-1:0];
                s_d.step = '0;
                s_d.active = 1'b1;
                // processor strobe ignores write controls on its first clock
                wr = stb_c & (|lane_we);
                // a read can start every clock, back to back
                s_d.rd = ~wr;
            end else begin
                // deselect; drive already carries the last read one clock on
                s_d.active = 1'b0;
            end
        end else if (s_q.active) begin
            if (!LINK.burst_advance_n) begin
                s_d.step = CNT_W'(s_q.step + 1'b1);
            end else begin
                s_d.step = s_q.step;
            end
            wr = |lane_we;
            s_d.rd = ~wr;
        end

        if (wr) begin
            wr_addr = burst_addr(s_d.base, s_d.start, s_d.step, s_q.order);
            for (int i = 0; i < LANES; i++) begin
                if (lane_we[i]) begin
                    // data lines captured at the edge into the addressed row
                    s_d.mem[wr_addr][i*LANE_W +: LANE_W] = LINK.dq[i*LANE_W +: LANE_W];
                end
            end
            // a detected write floats the outputs whatever the enable says
            s_d.drive = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign LINK.dev_dq = s_q.dout;
    // enable is asynchronous: gated after the register, not sampled
    assign LINK.dev_dq_oe = s_q.drive & ~LINK.out_drive_enable_n;
    assign SLEEP_ACTIVE = s_q.slp[1];
endmodule // pssp_dev

// ===== core/pssp_host.sv
// pssp_host: cache controller end of the sram link, ordered over apb.
// assumes one apb master on CORE_CLK and a pssp_dev at the far end.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/10ps
module pssp_host #(
    parameter int ADDR_W = pssp_pkg::DEF_ADDR_W
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [pssp_pkg::APB_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // sram link
    pssp_if.host_mp LINK
);
    import pssp_pkg::*;

    if (ADDR_W <= CNT_W || ADDR_W > MAX_ADDR_W || ADDR_W > 32) begin : g_bad_addr_w
        $error("pssp_host: ADDR_W out of range");
    end

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic sel1_n;
        logic sel2;
        logic sel3_n;
        logic pstb_n;
        logic cstb_n;
        logic step_n;
        logic allwr_n;
        logic bytewr_n;
        logic [LANES-1:0] lanes_n;
        logic oe_n;
        logic [DATA_W-1:0] dq;
        logic dq_oe;
    } pssp_pins_s;

    typedef struct packed {
        pssp_host_state_e st;
        pssp_pins_s pins;
        logic issuing;
        logic [1:0] pipe;
        logic [CNT_W-1:0] beat;
        logic [CNT_W:0] cap;
        logic op_write;
        logic op_cstb;
        logic [CNT_W-1:0] len_m1;
        logic [ADDR_W-1:0] addr;
        logic ilv;
        logic sleep;
        logic [LANES-1:0] lane_n;
        logic global_wr;
        logic [BEATS-1:0][DATA_W-1:0] wdata;
        logic [BEATS-1:0][DATA_W-1:0] rdata;
        logic done;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pssp_host_state_s;

    pssp_host_state_s s_q;
    pssp_host_state_s s_d;

    logic access;
    logic [31:0] rd_word;
    logic rd_err;

    // link at rest: deselected, strobes and writes idle, outputs floating
    function automatic pssp_pins_s pins_idle(input logic [ADDR_W-1:0] a);
        pssp_pins_s p;
        p = '0;
        p.addr = a;
        p.sel1_n = 1'b1;
        p.pstb_n = 1'b1;
        p.cstb_n = 1'b1;
        p.step_n = 1'b1;
        p.allwr_n = 1'b1;
        p.bytewr_n = 1'b1;
        p.lanes_n = '1;
        p.oe_n = 1'b1;
        return p;
    endfunction

    always_comb begin
        s_d = s_q;
        rd_word = '0;
        rd_err = 1'b0;
        access = PSEL & PENABLE & s_q.pready;

        // register read decode, done at setup so PRDATA leaves a flop
        if (PADDR[1:0] != 2'h0) begin
            rd_err = 1'b1;
        end else if (PADDR == OFS_CTRL) begin
            rd_word[CTRL_WRITE] = s_q.op_write;
            rd_word[CTRL_LEN +: CNT_W] = s_q.len_m1;
            rd_word[CTRL_CSTB] = s_q.op_cstb;
        end else if (PADDR == OFS_STATUS) begin
            rd_word[STAT_BUSY] = (s_q.st != PSSP_IDLE);
            rd_word[STAT_DONE] = s_q.done;
        end else if (PADDR == OFS_ADDR) begin
            rd_word = 32'(s_q.addr);
        end else if (PADDR == OFS_CFG) begin
            rd_word[CFG_ILV] = s_q.ilv;
            rd_word[CFG_SLEEP] = s_q.sleep;
            rd_word[CFG_LANE +: LANES] = s_q.lane_n;
            rd_word[CFG_GLOBAL] = s_q.global_wr;
        end else if (PADDR[7:4] == PAGE_WDATA) begin
            rd_word = 32'(s_q.wdata[PADDR[3:2]]);
        end else if (PADDR[7:4] == PAGE_RDATA) begin
            rd_word = 32'(s_q.rdata[PADDR[3:2]]);
        end else begin
            rd_err = 1'b1;
        end

        // one wait-free access phase after every setup
        s_d.pready = PSEL & ~PENABLE;
        s_d.prdata = (PSEL & ~PENABLE & ~PWRITE) ? rd_word : '0;
        s_d.pslverr = PSEL & ~PENABLE & rd_err;

        if (access && PWRITE && !rd_err) begin
            if (PADDR == OFS_STATUS && PWDATA[STAT_DONE]) begin
                s_d.done = 1'b0;
            end else if (PADDR == OFS_CTRL) begin
                s_d.op_write = PWDATA[CTRL_WRITE];
                s_d.len_m1 = PWDATA[CTRL_LEN +: CNT_W];
                s_d.op_cstb = PWDATA[CTRL_CSTB];
            end else if (PADDR == OFS_ADDR) begin
                s_d.addr = PWDATA[ADDR_W-1:0];
            end else if (PADDR == OFS_CFG) begin
                s_d.ilv = PWDATA[CFG_ILV];
                s_d.sleep = PWDATA[CFG_SLEEP];
                s_d.lane_n = PWDATA[CFG_LANE +: LANES];
                s_d.global_wr = PWDATA[CFG_GLOBAL];
            end else if (PADDR[7:4] == PAGE_WDATA) begin
                s_d.wdata[PADDR[3:2]] = PWDATA[DATA_W-1:0];
            end
        end

        // read data three edges after its beat was put on the pins
        s_d.pipe = {s_q.pipe[0], s_q.issuing};
        if (s_q.pipe[1]) begin
            s_d.rdata[s_q.cap[CNT_W-1:0]] = LINK.dq;
            s_d.cap = (CNT_W+1)'(s_q.cap + 1'b1);
        end

        case (s_q.st)
            PSSP_IDLE: begin
                // go is taken only when idle, from the same write
                if (access && PWRITE && PADDR == OFS_CTRL && PWDATA[CTRL_GO]) begin
                    s_d.st = PSSP_ISSUE;
                    s_d.beat = '0;
                    s_d.cap = '0;
                    s_d.pins = pins_idle(s_d.addr);
                    s_d.pins.sel1_n = 1'b0;
                    s_d.pins.sel2 = 1'b1;
                    s_d.pins.sel3_n = 1'b0;
                    if (s_d.op_write) begin
                        // controller strobe writes in one clock
                        s_d.pins.cstb_n = 1'b0;
                        s_d.pins.allwr_n = ~s_d.global_wr;
                        s_d.pins.bytewr_n = s_d.global_wr;
                        s_d.pins.lanes_n = s_d.lane_n;
                        s_d.pins.dq = s_d.wdata[0];
                        s_d.pins.dq_oe = 1'b1;
                    end else begin
                        s_d.pins.pstb_n = s_d.op_cstb;
                        s_d.pins.cstb_n = ~s_d.op_cstb;
                        s_d.pins.oe_n = 1'b0;
                    end
                    s_d.issuing = ~s_d.op_write;
                end
            end
            PSSP_ISSUE: begin
                if (s_q.beat == s_q.len_m1) begin
                    // end with a deselect; first select high mutes the
                    // processor strobe, so the controller strobe carries it
                    s_d.pins = pins_idle(s_q.addr);
                    s_d.pins.cstb_n = 1'b0;
                    s_d.pins.oe_n = s_q.op_write;
                    s_d.issuing = 1'b0;
                    s_d.st = s_q.op_write ? PSSP_IDLE : PSSP_DRAIN;
                end else begin
                    s_d.beat = CNT_W'(s_q.beat + 1'b1);
                    s_d.pins.pstb_n = 1'b1;
                    s_d.pins.cstb_n = 1'b1;
                    s_d.pins.step_n = 1'b0;
                    s_d.pins.dq = s_q.wdata[s_d.beat];
                end
            end
            PSSP_DRAIN: begin
                s_d.pins.cstb_n = 1'b1;
                if (s_q.cap == {1'b0, s_q.len_m1} + 1'b1) begin
                    s_d.pins.oe_n = 1'b1;
                    s_d.st = PSSP_IDLE;
                end
            end
            default: begin
                s_d.st = PSSP_IDLE;
                s_d.pins = pins_idle(s_q.addr);
            end
        endcase

        // completion sets done after any clear, so it is never lost
        if (s_q.st == PSSP_ISSUE && s_q.beat == s_q.len_m1 && s_q.op_write) begin
            s_d.done = 1'b1;
        end
        if (s_q.st == PSSP_DRAIN && s_d.st == PSSP_IDLE) begin
            s_d.done = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= '0;
            s_q.st <= PSSP_IDLE;
            s_q.pins.sel1_n <= 1'b1;
            s_q.pins.pstb_n <= 1'b1;
            s_q.pins.cstb_n <= 1'b1;
            s_q.pins.step_n <= 1'b1;
            s_q.pins.allwr_n <= 1'b1;
            s_q.pins.bytewr_n <= 1'b1;
            s_q.pins.lanes_n <= '1;
            s_q.pins.oe_n <= 1'b1;
            s_q.ilv <= CFG_ILV_RST;
            s_q.lane_n <= CFG_LANE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA = s_q.prdata;
    assign PREADY = s_q.pready;
    assign PSLVERR = s_q.pslverr;
    assign LINK.addr = s_q.pins.addr;
    assign LINK.first_chip_select_n = s_q.pins.sel1_n;
    assign LINK.second_chip_select = s_q.pins.sel2;
    assign LINK.third_chip_select_n = s_q.pins.sel3_n;
    assign LINK.processor_addr_strobe_n = s_q.pins.pstb_n;
    assign LINK.controller_addr_strobe_n = s_q.pins.cstb_n;
    assign LINK.burst_advance_n = s_q.pins.step_n;
    assign LINK.global_write_n = s_q.pins.allwr_n;
    assign LINK.byte_write_enable_n = s_q.pins.bytewr_n;
    assign LINK.byte_lane_select_n = s_q.pins.lanes_n;
    assign LINK.out_drive_enable_n = s_q.pins.oe_n;
    assign LINK.host_dq = s_q.pins.dq;
    assign LINK.host_dq_oe = s_q.pins.dq_oe;
    assign LINK.sleep_request = s_q.sleep;
    assign LINK.burst_order = s_q.ilv;
endmodule // pssp_host

// ===== verif/pssp_properties.sv
// pssp_properties: concurrent checks on the sram link pins.
// assumes one core clock and the link signals wired straight in.
`timescale 1ns/10ps
module pssp_properties (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // link pins
    input wire logic first_chip_select_n,
    input wire logic second_chip_select,
    input wire logic third_chip_select_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic out_drive_enable_n,
    input wire logic sleep_request,
    input wire logic dev_dq_oe
);
    logic sel, strobe, rd_ev, wr_ev, desel_ev, idle_ev, dsel_q;
    assign sel = !first_chip_select_n && second_chip_select && !third_chip_select_n;
    // processor strobe counts only with first select low
    assign strobe = (!processor_addr_strobe_n && !first_chip_select_n) || !controller_addr_strobe_n;
    assign rd_ev = strobe && sel && global_write_n && byte_write_enable_n;
    assign wr_ev = sel && !controller_addr_strobe_n && processor_addr_strobe_n
        && !(global_write_n && byte_write_enable_n);
    assign desel_ev = strobe && !sel;
    assign idle_ev = controller_addr_strobe_n && processor_addr_strobe_n && !sleep_request;
    // device leaves reset deselected
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            dsel_q <= 1'b1;
        end else if (strobe) begin
            dsel_q <= !sel;
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    property p_oe_float;
        out_drive_enable_n |-> !dev_dq_oe;
    endproperty
    a_oe_float: assert property (p_oe_float)
        else $error("data driven with output enable high");
    property p_first_read;
        rd_ev && dsel_q |=> !dev_dq_oe;
    endproperty
    a_first_read: assert property (p_first_read)
        else $error("first read clock after deselect driven");
    property p_read_drive;
        rd_ev ##1 idle_ev ##1 !out_drive_enable_n |-> dev_dq_oe;
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("read data not driven one clock after address");
    property p_write_float;
        wr_ev |=> !dev_dq_oe;
    endproperty
    a_write_float: assert property (p_write_float)
        else $error("data driven after write cycle");
    property p_dcd_hold;
        desel_ev && !dsel_q && dev_dq_oe ##1 !out_drive_enable_n |-> dev_dq_oe;
    endproperty
    a_dcd_hold: assert property (p_dcd_hold)
        else $error("drive dropped at deselect edge");
    property p_dcd_off;
        desel_ev |-> ##2 !dev_dq_oe;
    endproperty
    a_dcd_off: assert property (p_dcd_off)
        else $error("drive kept past clock after deselect");
    property p_sleep_float;
        sleep_request [*3] |-> !dev_dq_oe;
    endproperty
    a_sleep_float: assert property (p_sleep_float)
        else $error("data driven while asleep");
    property p_read_strobe;
        !processor_addr_strobe_n |-> global_write_n && byte_write_enable_n;
    endproperty
    a_read_strobe: assert property (p_read_strobe)
        else $error("processor strobe with write controls low");
    c_read: cover property (rd_ev ##1 idle_ev ##1 dev_dq_oe);
    c_write: cover property (wr_ev);
    c_desel: cover property (desel_ev && dev_dq_oe);
endmodule // pssp_properties

// ===== verif/testbench.sv
// testbench: apb-driven controller end facing the sram end.
// assumes pssp_pkg, pssp_if, pssp_host and pssp_dev compiled before.
`timescale 1ns/10ps
module testbench;
    import pssp_pkg::*;
    logic CORE_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SLEEP_ACTIVE;
    logic [APB_AW-1:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic [17:0] mem [4];
    int failures, n_checks, cyc;
    pssp_if u_pssp_if();
    pssp_host u_pssp_host(.CORE_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .LINK(u_pssp_if.host_mp));
    pssp_dev u_pssp_dev(.CORE_CLK, .RST_N, .LINK(u_pssp_if.dev_mp), .SLEEP_ACTIVE);
    pssp_properties u_pssp_properties(.CORE_CLK, .RST_N,
        .first_chip_select_n(u_pssp_if.first_chip_select_n),
        .second_chip_select(u_pssp_if.second_chip_select),
        .third_chip_select_n(u_pssp_if.third_chip_select_n),
        .processor_addr_strobe_n(u_pssp_if.processor_addr_strobe_n),
        .controller_addr_strobe_n(u_pssp_if.controller_addr_strobe_n),
        .global_write_n(u_pssp_if.global_write_n),
        .byte_write_enable_n(u_pssp_if.byte_write_enable_n),
        .out_drive_enable_n(u_pssp_if.out_drive_enable_n),
        .sleep_request(u_pssp_if.sleep_request), .dev_dq_oe(u_pssp_if.dev_dq_oe));
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one transfer; the global cycle ceiling cuts a missing pready
    task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        @(posedge CORE_CLK);
        while (PREADY !== 1'b1) @(posedge CORE_CLK);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rdchk(input logic [APB_AW-1:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask
    // start a link transfer, poll done, then clear it
    task automatic run(input logic [31:0] ctrl);
        logic [31:0] s;
        logic e;
        int n;
        s = 32'h0;
        n = 0;
        wr(OFS_CTRL, ctrl);
        while (s[STAT_DONE] !== 1'b1 && n < 40) begin
            apb(1'b0, OFS_STATUS, 32'h0, s, e);
            n++;
        end
        chk(s, 32'h2);
        wr(OFS_STATUS, 32'h2);
    endtask
    initial begin
        CORE_CLK = 1'b0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        logic [31:0] q;
        logic e;
        RST_N = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = '0;
        PWDATA = '0;
        repeat (6) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        rdchk(OFS_CFG, 32'h1);
        rdchk(OFS_STATUS, 32'h0);
        // interleaved burst write from start 01, both lanes by byte write
        wr(OFS_ADDR, 32'h11);
        for (int k = 0; k < BEATS; k++) begin
            wr({PAGE_WDATA, 4'(4 * k)}, 32'h2A5A0 + k);
            mem[2'(1) ^ 2'(k)] = 18'(32'h2A5A0 + k);
        end
        run(32'h0F);
        // lane 0 only, then global write overriding cleared lane selects
        wr(OFS_CFG, 32'h8);
        wr(OFS_ADDR, 32'h10);
        wr({PAGE_WDATA, 4'h0}, 32'h3FFFF);
        run(32'h03);
        mem[0][8:0] = 9'h1FF;
        wr(OFS_CFG, 32'h1C);
        wr(OFS_ADDR, 32'h12);
        wr({PAGE_WDATA, 4'h0}, 32'h12345);
        run(32'h03);
        mem[2] = 18'h12345;
        // sleep must keep contents
        wr(OFS_CFG, 32'h3);
        repeat (8) @(posedge CORE_CLK);
        chk(32'(SLEEP_ACTIVE), 32'h1);
        wr(OFS_CFG, 32'h1);
        repeat (4) @(posedge CORE_CLK);
        chk(32'(SLEEP_ACTIVE), 32'h0);
        // single reads, alternating strobes
        for (int a = 0; a < 4; a++) begin
            wr(OFS_ADDR, 32'h10 + a);
            run((a % 2) ? 32'h11 : 32'h01);
            rdchk({PAGE_RDATA, 4'h0}, 32'(mem[a]));
        end
        // four-beat read bursts from start 01, interleaved then linear
        for (int m = 0; m < 2; m++) begin
            wr(OFS_CFG, 32'(1 - m));
            wr(OFS_ADDR, 32'h11);
            run(32'h0D);
            for (int k = 0; k < BEATS; k++) begin
                rdchk({PAGE_RDATA, 4'(4 * k)}, 32'(mem[m ? 2'(1 + k) : 2'(1) ^ 2'(k)]));
            end
        end
        // unaligned and unmapped places
        apb(1'b0, 8'h02, 32'h0, q, e);
        chk(32'(e), 32'h1);
        apb(1'b1, 8'h40, 32'h0, q, e);
        chk(32'(e), 32'h1);
        stop_test();
    end
endmodule // testbench
